// ===== src/fbc_params.svh
// Constants for the framebuffer configuration register bank.
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH
// ----------------------------------------
// Register indices on the register port
// ----------------------------------------
`define FBC_IDX_TIMING     3'h0
`define FBC_IDX_MODE       3'h1
`define FBC_IDX_CWMASK     3'h2
`define FBC_IDX_COLLO      3'h3
`define FBC_IDX_SHARE      3'h4
`define FBC_IDX_BYPMASK    3'h5
`define FBC_IDX_COLHI      3'h6
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FBC_REFRESH_RST    8'h20
`define FBC_TIMEOUT_RST    4'h0
`define FBC_BYPMASK_RST    32'hFFFFFFFF
`define FBC_ZERO32         32'h00000000
// ----------------------------------------
// Strap positions on the depth-buffer data pins
// ----------------------------------------
`define FBC_SP_PAGEDIS     6
`define FBC_SP_FASTDIS     10
`define FBC_SP_XFERDIS     13
`define FBC_SP_EXTVTG      14
`define FBC_SP_DUALWE      19
`define FBC_SP_ENHSHR      20
`define FBC_SP_SWAP        21
// ----------------------------------------
// Timing, fixed mode bits and sharing role codes
// ----------------------------------------
`define FBC_TICK_LAST      4'hF
`define FBC_STRAP_WAIT     2'h3
`define FBC_MODE_FIXED     3'h7
`define FBC_ROLE_PRIMARY   2'h1
`define FBC_ROLE_SECONDARY 2'h2
`endif

// ===== src/fbc_pkg.sv
// Types shared by the framebuffer configuration modules.
package fbc_pkg;
	// Startup sequence of the strap loader, one-hot.
	typedef enum logic [2:0] {
		FBC_ST_WAIT = 3'h1,
		FBC_ST_LOAD = 3'h2,
		FBC_ST_RUN  = 3'h4
	} fbc_state_t;
	typedef logic [1:0] fbc_code2_t;
endpackage

// ===== src/fbc_timer_if.sv
// Carrier between the register bank and one sixteen-clock tick timer.
`timescale 1ns/1ps
`default_nettype none
interface fbc_timer_if;
	logic       load;     // Restart with val.
	logic       auto_rl;  // Reload on expiry and pulse.
	logic [7:0] val;      // Count in units of sixteen clocks.
	logic       expired;  // Count has reached zero.
	logic       pulse;    // One cycle at each automatic reload.
	modport ctl (output load, output auto_rl, output val, input expired, input pulse);
	modport tmr (input load, input auto_rl, input val, output expired, output pulse);
endinterface
`default_nettype wire

// ===== src/fbc_pin_sync.sv
// Three-stage synchroniser; a change is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module fbc_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_ff;  // Metastable stage, read only by s2_ff.
	logic [W-1:0] s2_ff;  // Second stage.
	logic [W-1:0] s3_ff;  // Third stage.
	logic [W-1:0] hold_ff;  // Last agreed value.

	// ----------------------------------------
	// Shift chain and agreement filter
	// ----------------------------------------
	// Only bits where the last two stages agree are passed, which rejects
	// a single-cycle glitch that slipped through the first stage.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			hold_ff <= '0;
		end else if (ce) begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			hold_ff <= (s2_ff & s3_ff) | (hold_ff & (s2_ff | s3_ff));
		end
	end
	assign pin_out = hold_ff;
endmodule
`default_nettype wire

// ===== src/fbc_tick_timer.sv
// Down counter decremented once every sixteen clocks.
`timescale 1ns/1ps
`default_nettype none
`include "fbc_params.svh"
module fbc_tick_timer (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic ce,
	fbc_timer_if.tmr  t
);
	logic [3:0] pre_ff;  // Sixteen-clock prescaler.
	logic [7:0] cnt_ff;  // Remaining units.
	logic       pulse_ff;  // Reload marker.

	// ----------------------------------------
	// Count
	// ----------------------------------------
	// A load restarts the prescaler so the first unit is a full sixteen.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_ff <= '0;
			cnt_ff <= '0;
			pulse_ff <= 1'b0;
		end else if (ce) begin
			pulse_ff <= 1'b0;
			if (t.load) begin
				pre_ff <= '0;
				cnt_ff <= t.val;
			end else begin
				pre_ff <= pre_ff + 4'h1;
				if (pre_ff == `FBC_TICK_LAST && cnt_ff != 8'h00) begin
					if (cnt_ff == 8'h01 && t.auto_rl) begin
						cnt_ff <= t.val;
						pulse_ff <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
			end
		end
	end
	assign t.expired = (cnt_ff == 8'h00);
	assign t.pulse = pulse_ff;
endmodule
`default_nettype wire

// ===== src/fbc_regs.sv
// Framebuffer configuration and status register bank.
`timescale 1ns/1ps
`default_nettype none
`include "fbc_params.svh"
module fbc_regs
	import fbc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        reg_sel,
	input  wire logic        reg_wr,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_ack,
	input  wire logic [31:0] strap_pins,
	input  wire logic        enhanced_mode_pin,
	input  wire logic [31:0] core_write_mask,
	input  wire logic [63:0] core_colour,
	input  wire logic        byp_wr_valid,
	input  wire logic [31:0] byp_new_data,
	input  wire logic [31:0] byp_old_data,
	output logic             byp_out_valid,
	output logic      [31:0] byp_out_data,
	input  wire logic        sec_req,
	input  wire logic        own_req,
	input  wire logic        own_grant,
	input  wire logic        sec_grant,
	output logic             sec_req_accept,
	output logic             own_req_gated,
	output logic      [2:0]  ras_cas_clks,
	output logic      [2:0]  precharge_clks,
	output logic      [2:0]  cas_clks,
	output logic             page_mode_en,
	output logic             refresh_req,
	output logic             fast_mode_en,
	output logic             transfer_en,
	output logic             ext_timing_sel,
	output logic      [1:0]  interleave_ways,
	output logic      [1:0]  block_fill_size,
	output logic             dual_write_enable,
	output logic      [15:0] class_code,
	output logic      [2:0]  window_size,
	output logic      [1:0]  sharing_role,
	output logic             legacy_share_compat,
	output logic             straps_loaded
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	fbc_state_t  st_ff;         // Strap loader state.
	logic [1:0]  wait_ff;       // Cycles waited for synchroniser fill.
	logic [31:0] strap_s;       // Synchronised strap pins.
	logic        enh_s;         // Synchronised enhanced-mode pin.
	fbc_code2_t  rascas_ff;     // Timing bits 1-0.
	fbc_code2_t  prech_ff;      // Timing bits 3-2.
	fbc_code2_t  caslow_ff;     // Timing bits 5-4.
	logic [7:0]  refresh_ff;    // Timing bits 13-6.
	logic        pagedis_ff;    // Timing bit 14.
	logic [8:0]  tstrap_ff;     // Timing bits 31-23, straps.
	logic        edo_ff;        // Timing bit 22.
	logic        fastdis_ff;    // Mode bit 3.
	fbc_code2_t  shmode_ff;     // Mode bits 5-4.
	logic        xferdis_ff;    // Mode bit 6.
	logic        extvtg_ff;     // Mode bit 7.
	fbc_code2_t  ilv_ff;        // Mode bits 9-8.
	fbc_code2_t  bfill_ff;      // Mode bits 11-10.
	logic        dualwe_ff;     // Mode bit 12.
	logic        compat_ff;     // Share bit 0.
	logic        enhshr_ff;     // Share bit 2, strap.
	logic [3:0]  pto_ff;        // Share bits 6-3.
	logic [3:0]  sto_ff;        // Share bits 10-7.
	logic        swap_ff;       // Share bit 11 (sharing_role_swap).
	logic [31:0] bypmask_ff;    // Bypass write mask.
	logic        wr_en;         // Host write this cycle.
	logic        refresh_wr;    // Refresh count rewritten.
	logic        refresh_wr_q_ff; // Refresh count rewritten last cycle.
	logic        sec_grant_q_ff;  // Secondary grant seen last cycle.
	logic [31:0] nxt_rdata;     // Read mux.
	logic [31:0] timing_word;   // Assembled timing register.
	logic [31:0] mode_word;     // Assembled mode register.
	logic [31:0] share_word;    // Assembled share register.
	fbc_code2_t  eff_role;      // Role after enhanced decode.
	logic [31:0] byp_merge;     // Masked bypass data.
	fbc_timer_if ref_t ();      // Refresh timer.
	fbc_timer_if pto_t ();      // Primary timeout.
	fbc_timer_if sto_t ();      // Secondary timeout.

	// Code-to-clocks decode shared by the three timing fields.
	function automatic logic [2:0] code_clks(input fbc_code2_t code, input logic [2:0] base);
		code_clks = {1'b0, code} + base;
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	fbc_pin_sync #(.W(32)) u_strap_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.pin_in   (strap_pins),
		.pin_out  (strap_s)
	);
	fbc_pin_sync #(.W(1)) u_enh_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.pin_in   (enhanced_mode_pin),
		.pin_out  (enh_s)
	);

	// ----------------------------------------
	// Strap loader
	// ----------------------------------------
	// Straps are captured a few edges after reset release so the
	// synchronisers hold settled pin values; reset itself loads constants.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= FBC_ST_WAIT;
			wait_ff <= '0;
		end else if (ce) begin
			case (st_ff)
				FBC_ST_WAIT: begin
					wait_ff <= wait_ff + 2'h1;
					if (wait_ff == `FBC_STRAP_WAIT) begin
						st_ff <= FBC_ST_LOAD;
					end
				end
				FBC_ST_LOAD: begin
					st_ff <= FBC_ST_RUN;
				end
				FBC_ST_RUN: begin
					st_ff <= FBC_ST_RUN;
				end
				default: begin
					st_ff <= FBC_ST_WAIT;
				end
			endcase
		end
	end

	assign wr_en = reg_sel & reg_wr;
	assign refresh_wr = wr_en & (reg_addr == `FBC_IDX_TIMING);

	// ----------------------------------------
	// Memory timing register
	// ----------------------------------------
	// The strap load wins over a host write landing in the same cycle.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rascas_ff <= '0;
			prech_ff <= '0;
			caslow_ff <= '0;
			refresh_ff <= `FBC_REFRESH_RST;
			pagedis_ff <= 1'b0;
			tstrap_ff <= '0;
			edo_ff <= 1'b0;
		end else if (ce) begin
			if (st_ff == FBC_ST_LOAD) begin
				rascas_ff <= strap_s[1:0];
				prech_ff <= strap_s[3:2];
				caslow_ff <= strap_s[5:4];
				pagedis_ff <= strap_s[`FBC_SP_PAGEDIS];
				edo_ff <= strap_s[22];
				tstrap_ff <= strap_s[31:23];
			end else if (refresh_wr) begin
				// Bits 31-15 are read-only and ignore writes.
				rascas_ff <= reg_wdata[1:0];
				prech_ff <= reg_wdata[3:2];
				caslow_ff <= reg_wdata[5:4];
				refresh_ff <= reg_wdata[13:6];
				pagedis_ff <= reg_wdata[14];
			end
		end
	end

	// ----------------------------------------
	// Mode select register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fastdis_ff <= 1'b0;
			shmode_ff <= '0;
			xferdis_ff <= 1'b0;
			extvtg_ff <= 1'b0;
			ilv_ff <= '0;
			bfill_ff <= '0;
			dualwe_ff <= 1'b0;
		end else if (ce) begin
			if (st_ff == FBC_ST_LOAD) begin
				fastdis_ff <= strap_s[`FBC_SP_FASTDIS];
				shmode_ff <= strap_s[12:11];
				xferdis_ff <= strap_s[`FBC_SP_XFERDIS];
				extvtg_ff <= strap_s[`FBC_SP_EXTVTG];
				ilv_ff <= strap_s[16:15];
				bfill_ff <= strap_s[18:17];
				dualwe_ff <= strap_s[`FBC_SP_DUALWE];
			end else if (wr_en && reg_addr == `FBC_IDX_MODE) begin
				// The shared mode field is read-only and keeps its strap.
				fastdis_ff <= reg_wdata[3];
				xferdis_ff <= reg_wdata[6];
				extvtg_ff <= reg_wdata[7];
				ilv_ff <= reg_wdata[9:8];
				bfill_ff <= reg_wdata[11:10];
				dualwe_ff <= reg_wdata[12];
			end
		end
	end

	// ----------------------------------------
	// Shared memory control and bypass mask
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			compat_ff <= 1'b0;
			enhshr_ff <= 1'b0;
			pto_ff <= `FBC_TIMEOUT_RST;
			sto_ff <= `FBC_TIMEOUT_RST;
			swap_ff <= 1'b0;
			bypmask_ff <= `FBC_BYPMASK_RST;
		end else if (ce) begin
			if (st_ff == FBC_ST_LOAD) begin
				enhshr_ff <= strap_s[`FBC_SP_ENHSHR];
				swap_ff <= strap_s[`FBC_SP_SWAP];
			end else if (wr_en && reg_addr == `FBC_IDX_SHARE) begin
				compat_ff <= reg_wdata[0];
				pto_ff <= reg_wdata[6:3];
				sto_ff <= reg_wdata[10:7];
			end
			if (wr_en && reg_addr == `FBC_IDX_BYPMASK) begin
				bypmask_ff <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Register word assembly and read mux
	// ----------------------------------------
	// Reserved bits are tied to zero here, so reads never expose them.
	always_comb begin
		timing_word = `FBC_ZERO32;
		timing_word[1:0] = rascas_ff;
		timing_word[3:2] = prech_ff;
		timing_word[5:4] = caslow_ff;
		timing_word[13:6] = refresh_ff;
		timing_word[14] = pagedis_ff;
		timing_word[22] = edo_ff;
		timing_word[31:23] = tstrap_ff;
		timing_word[21] = 1'b0;
		mode_word = `FBC_ZERO32;
		mode_word[2:0] = `FBC_MODE_FIXED;
		mode_word[3] = fastdis_ff;
		mode_word[5:4] = shmode_ff;
		mode_word[6] = xferdis_ff;
		mode_word[7] = extvtg_ff;
		mode_word[9:8] = ilv_ff;
		mode_word[11:10] = bfill_ff;
		mode_word[12] = dualwe_ff;
		share_word = `FBC_ZERO32;
		share_word[0] = compat_ff;
		share_word[1] = enh_s;
		share_word[2] = enhshr_ff & enh_s;
		share_word[6:3] = pto_ff;
		share_word[10:7] = sto_ff;
		share_word[11] = swap_ff;
		case (reg_addr)
			`FBC_IDX_TIMING: nxt_rdata = timing_word;
			`FBC_IDX_MODE: nxt_rdata = mode_word;
			`FBC_IDX_CWMASK: nxt_rdata = core_write_mask;
			`FBC_IDX_COLLO: nxt_rdata = core_colour[31:0];
			`FBC_IDX_SHARE: nxt_rdata = share_word;
			`FBC_IDX_BYPMASK: nxt_rdata = bypmask_ff;
			`FBC_IDX_COLHI: nxt_rdata = core_colour[63:32];
			default: nxt_rdata = `FBC_ZERO32;
		endcase
	end

	// ----------------------------------------
	// Register port answer
	// ----------------------------------------
	// Every access is answered one edge later; write data is dropped on
	// read-only views, and the read data of a write cycle is zero.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
			reg_ack <= 1'b0;
		end else if (ce) begin
			reg_ack <= reg_sel;
			reg_rdata <= (reg_sel && !reg_wr) ? nxt_rdata : `FBC_ZERO32;
		end
	end

	// ----------------------------------------
	// Sharing role decode
	// ----------------------------------------
	// In enhanced mode the swap bit exchanges the primary and secondary
	// roles; the full enhanced table is outside this bank.
	always_comb begin
		eff_role = shmode_ff;
		if (enhshr_ff && enh_s && swap_ff) begin
			case (shmode_ff)
				`FBC_ROLE_PRIMARY: eff_role = `FBC_ROLE_SECONDARY;
				`FBC_ROLE_SECONDARY: eff_role = `FBC_ROLE_PRIMARY;
				default: eff_role = shmode_ff;
			endcase
		end
	end

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	// The reload follows the write by a cycle so the new count is used; the
	// secondary timeout starts on the grant's rising edge, not its level.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			refresh_wr_q_ff <= 1'b0;
			sec_grant_q_ff <= 1'b0;
		end else if (ce) begin
			refresh_wr_q_ff <= refresh_wr;
			sec_grant_q_ff <= sec_grant;
		end
	end

	// The refresh timer restarts when the count is rewritten so a new
	// period takes effect at once; a count of zero stops refresh.
	assign ref_t.load = refresh_wr_q_ff | (st_ff != FBC_ST_RUN);
	assign ref_t.auto_rl = 1'b1;
	assign ref_t.val = refresh_ff;
	assign pto_t.load = own_grant;
	assign pto_t.auto_rl = 1'b0;
	assign pto_t.val = {4'h0, pto_ff};
	assign sto_t.load = sec_grant & ~sec_grant_q_ff;
	assign sto_t.auto_rl = 1'b0;
	assign sto_t.val = {4'h0, sto_ff};

	fbc_tick_timer u_ref_tmr (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.t        (ref_t.tmr)
	);
	fbc_tick_timer u_pto_tmr (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.t        (pto_t.tmr)
	);
	fbc_tick_timer u_sto_tmr (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.t        (sto_t.tmr)
	);

	// Bypass merge: masked bits come from new data, others stay.
	assign byp_merge = (byp_new_data & bypmask_ff) | (byp_old_data & ~bypmask_ff);

	// ----------------------------------------
	// Registered controls towards the sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ras_cas_clks <= '0;
			precharge_clks <= '0;
			cas_clks <= '0;
			page_mode_en <= 1'b0;
			refresh_req <= 1'b0;
			fast_mode_en <= 1'b0;
			transfer_en <= 1'b0;
			ext_timing_sel <= 1'b0;
			interleave_ways <= '0;
			block_fill_size <= '0;
			dual_write_enable <= 1'b0;
			class_code <= '0;
			window_size <= '0;
			sharing_role <= '0;
			legacy_share_compat <= 1'b0;
			straps_loaded <= 1'b0;
			sec_req_accept <= 1'b0;
			own_req_gated <= 1'b0;
			byp_out_valid <= 1'b0;
			byp_out_data <= '0;
		end else if (ce) begin
			ras_cas_clks <= code_clks(rascas_ff, 3'h2);
			precharge_clks <= code_clks(prech_ff, 3'h2);
			cas_clks <= code_clks(caslow_ff, 3'h1);
			page_mode_en <= ~pagedis_ff;
			refresh_req <= ref_t.pulse;
			fast_mode_en <= ~fastdis_ff;
			transfer_en <= ~xferdis_ff;
			ext_timing_sel <= extvtg_ff;
			interleave_ways <= ilv_ff;
			block_fill_size <= bfill_ff;
			dual_write_enable <= dualwe_ff;
			class_code <= tstrap_ff[3] ? 16'h0000 : 16'h0380;
			window_size <= tstrap_ff[8:6];
			sharing_role <= eff_role;
			legacy_share_compat <= compat_ff;
			straps_loaded <= (st_ff == FBC_ST_RUN);
			sec_req_accept <= sec_req & pto_t.expired & (eff_role == `FBC_ROLE_PRIMARY);
			own_req_gated <= own_req & ((eff_role != `FBC_ROLE_PRIMARY) | ~sec_grant
				| sto_t.expired);
			byp_out_valid <= byp_wr_valid;
			byp_out_data <= byp_wr_valid ? byp_merge : byp_out_data;
		end
	end
endmodule
`default_nettype wire

// ===== dv/fbc_regs_checker.sv
// Concurrent checks on the ports of the framebuffer configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module fbc_regs_checker (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        reg_sel,
	input wire logic        reg_wr,
	input wire logic [2:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_ack,
	input wire logic [31:0] core_write_mask,
	input wire logic [63:0] core_colour,
	input wire logic        byp_wr_valid,
	input wire logic        byp_out_valid,
	input wire logic [31:0] strap_pins,
	input wire logic [15:0] class_code,
	input wire logic [2:0]  window_size,
	input wire logic        straps_loaded,
	input wire logic [2:0]  ras_cas_clks,
	input wire logic [2:0]  precharge_clks,
	input wire logic [2:0]  cas_clks,
	input wire logic        page_mode_en,
	input wire logic        refresh_req
);
	// ----------------------------------------
	// Register port and views
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Every accepted cycle gets its answer on the very next edge, and nothing else does.
	ack_follows_a: assert property (ce && reg_sel |=> reg_ack) else $error("ack missing");
	ack_idle_a: assert property (ce && !reg_sel |=> !reg_ack) else $error("stray ack");
	unmapped_zero_a: assert property (ce && reg_sel && !reg_wr && reg_addr == 3'h7 |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
	mask_view_a: assert property (ce && reg_sel && !reg_wr && reg_addr == 3'h2 |=> reg_rdata == $past(core_write_mask)) else $error("mask view wrong");
	colour_high_a: assert property (ce && reg_sel && !reg_wr && reg_addr == 3'h6 |=> reg_rdata == $past(core_colour[63:32])) else $error("colour view wrong");
	// Straps are only trusted once the loader has settled for a cycle.
	class_code_a: assert property (straps_loaded && $past(straps_loaded) |-> class_code == (strap_pins[26] ? 16'h0000 : 16'h0380)) else $error("class code wrong");
	window_size_a: assert property (straps_loaded && $past(straps_loaded) |-> window_size == strap_pins[31:29]) else $error("window size wrong");
	// Derived timing outputs follow a timing write two edges later.
	timing_codes_a: assert property (straps_loaded && ce && reg_sel && reg_wr && reg_addr == 3'h0 |-> ##2 (ras_cas_clks == {1'b0, $past(reg_wdata[1:0], 2)} + 3'h2 && precharge_clks == {1'b0, $past(reg_wdata[3:2], 2)} + 3'h2 && cas_clks == {1'b0, $past(reg_wdata[5:4], 2)} + 3'h1 && page_mode_en == !$past(reg_wdata[14], 2))) else $error("timing outputs wrong");
	// Bypass result appears exactly one cycle after each request.
	byp_pulse_a: assert property (ce |=> byp_out_valid == $past(byp_wr_valid)) else $error("bypass valid wrong");
	cover property (ce && reg_sel && reg_wr);
	cover property (refresh_req);
	cover property (byp_out_valid);
endmodule
bind fbc_regs fbc_regs_checker i_fbc_regs_checker (.core_clk(core_clk), .rst(rst), .ce(ce),
	.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_ack(reg_ack), .core_write_mask(core_write_mask),
	.core_colour(core_colour), .byp_wr_valid(byp_wr_valid), .byp_out_valid(byp_out_valid),
	.strap_pins(strap_pins), .class_code(class_code), .window_size(window_size),
	.straps_loaded(straps_loaded), .ras_cas_clks(ras_cas_clks), .precharge_clks(precharge_clks),
	.cas_clks(cas_clks), .page_mode_en(page_mode_en), .refresh_req(refresh_req));
`default_nettype wire

// ===== dv/fbc_regs_bench.sv
// Self-checking bench for the framebuffer configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module fbc_regs_bench;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        core_clk = 1'b0, rst = 1'b1, ce = 1'b1, enh_pin = 1'b1;
	logic        reg_sel = 1'b0, reg_wr = 1'b0, byp_wr_valid = 1'b0;
	logic [2:0]  reg_addr = 3'h0;
	logic [31:0] reg_wdata = 32'h0, byp_new_data = 32'h0, byp_old_data = 32'h0;
	logic        sec_req = 1'b0, own_req = 1'b0, own_grant = 1'b0, sec_grant = 1'b0;
	logic [31:0] strap_pins = 32'hA0534C79; // Board options held steady for the whole run.
	logic [31:0] mask = 32'h5A5A0F0F;
	logic [63:0] colour = 64'h0123456789ABCDEF;
	logic [31:0] reg_rdata, byp_out_data, q;
	logic        reg_ack, byp_out_valid, sec_req_accept, own_req_gated, page_mode_en;
	logic        refresh_req, fast_mode_en, transfer_en, ext_timing_sel, dual_write_enable;
	logic        legacy_share_compat, straps_loaded;
	logic [2:0]  ras_cas_clks, precharge_clks, cas_clks, window_size;
	logic [1:0]  interleave_ways, block_fill_size, sharing_role;
	logic [15:0] class_code;
	int          fails = 0, checked = 0, n;
	always #12.5 core_clk = ~core_clk;
	fbc_regs i_fbc_regs (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_sel(reg_sel),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_ack(reg_ack), .strap_pins(strap_pins), .enhanced_mode_pin(enh_pin),
		.core_write_mask(mask), .core_colour(colour), .byp_wr_valid(byp_wr_valid),
		.byp_new_data(byp_new_data), .byp_old_data(byp_old_data), .byp_out_valid(byp_out_valid),
		.byp_out_data(byp_out_data), .sec_req(sec_req), .own_req(own_req), .own_grant(own_grant),
		.sec_grant(sec_grant), .sec_req_accept(sec_req_accept), .own_req_gated(own_req_gated),
		.ras_cas_clks(ras_cas_clks), .precharge_clks(precharge_clks), .cas_clks(cas_clks),
		.page_mode_en(page_mode_en), .refresh_req(refresh_req), .fast_mode_en(fast_mode_en),
		.transfer_en(transfer_en), .ext_timing_sel(ext_timing_sel),
		.interleave_ways(interleave_ways), .block_fill_size(block_fill_size),
		.dual_write_enable(dual_write_enable), .class_code(class_code),
		.window_size(window_size), .sharing_role(sharing_role),
		.legacy_share_compat(legacy_share_compat), .straps_loaded(straps_loaded));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Prints the totals and the verdict, then ends the run.
	task automatic summarize();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// A wait that used up its bound counts as a mismatch and ends the run.
	task automatic lim(input int c, input int m);
		if (c >= m) begin
			fails++;
			summarize();
		end
	endtask
	// One register cycle; taken at the next edge, answered one edge later.
	task automatic acc(input logic wr, input logic [2:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		reg_sel <= 1'b1;
		reg_wr <= wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_sel <= 1'b0;
		do begin
			@(posedge core_clk);
			k++;
		end while (reg_ack !== 1'b1 && k < 8);
		q = reg_rdata;
		lim(k, 8);
	endtask
	task automatic rd(input logic [2:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cyc(10);
		rst <= 1'b0;
		n = 0;
		while (straps_loaded !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		lim(n, 50);
		cyc(2);
		chk({ras_cas_clks, precharge_clks, cas_clks, page_mode_en}, {3'h3, 3'h4, 3'h4, 1'b0});
		chk({class_code, window_size, sharing_role}, {16'h0380, 3'h5, 2'h1});
		chk({fast_mode_en, transfer_en, ext_timing_sel, interleave_ways, block_fill_size, dual_write_enable}, {3'h3, 2'h2, 2'h1, 1'b0});
		rd(3'h0, 32'hA0404839);
		rd(3'h1, 32'h0000069F);
		rd(3'h2, mask);
		rd(3'h3, colour[31:0]);
		rd(3'h4, 32'h00000006);
		rd(3'h5, 32'hFFFFFFFF);
		rd(3'h6, colour[63:32]);
		// Writes to views and to the hole must change nothing.
		acc(1'b1, 3'h2, 32'h0);
		acc(1'b1, 3'h7, 32'hFFFFFFFF);
		rd(3'h2, mask);
		rd(3'h7, 32'h0);
		acc(1'b1, 3'h0, 32'hFFFFFFFF);
		cyc(2);
		chk({ras_cas_clks, precharge_clks, cas_clks, page_mode_en}, {3'h5, 3'h5, 3'h4, 1'b0});
		rd(3'h0, 32'hA0407FFF);
		acc(1'b1, 3'h0, 32'h00000080);
		cyc(2);
		chk({ras_cas_clks, precharge_clks, cas_clks, page_mode_en}, {3'h2, 3'h2, 3'h1, 1'b1});
		// A refresh count of two must space pulses thirty-two clocks apart.
		n = 0;
		while (refresh_req !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		lim(n, 100);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (refresh_req !== 1'b1 && n < 100);
		chk(n, 32);
		lim(n, 100);
		acc(1'b1, 3'h1, 32'hFFFFFFFF);
		cyc(2);
		rd(3'h1, 32'h00001FDF);
		chk({fast_mode_en, transfer_en, ext_timing_sel, interleave_ways, block_fill_size, dual_write_enable}, {3'h1, 2'h3, 2'h3, 1'b1});
		acc(1'b1, 3'h1, 32'h0);
		cyc(2);
		rd(3'h1, 32'h00000017);
		chk({fast_mode_en, transfer_en, ext_timing_sel, interleave_ways, block_fill_size, dual_write_enable}, {3'h6, 2'h0, 2'h0, 1'b0});
		// Bypass merge through a programmed mask.
		acc(1'b1, 3'h5, 32'hFF00FF00);
		byp_wr_valid <= 1'b1;
		byp_new_data <= 32'h12345678;
		byp_old_data <= 32'h9ABCDEF0;
		cyc(1);
		byp_wr_valid <= 1'b0;
		cyc(1);
		chk({byp_out_valid, byp_out_data}, {1'b1, 32'h12BC56F0});
		// A low clock enable freezes the bank, so this request is not taken.
		ce <= 1'b0;
		byp_wr_valid <= 1'b1;
		cyc(2);
		chk(byp_out_valid, 1'b0);
		ce <= 1'b1;
		byp_wr_valid <= 1'b0;
		acc(1'b1, 3'h4, 32'hFFFFFFFF);
		rd(3'h4, 32'h000007FF);
		// Primary timeout of two units holds off the secondary after a grant.
		acc(1'b1, 3'h4, 32'h00000010);
		sec_req <= 1'b1;
		cyc(3);
		chk({legacy_share_compat, sec_req_accept}, 2'h1);
		own_grant <= 1'b1;
		cyc(1);
		own_grant <= 1'b0;
		cyc(8);
		chk(sec_req_accept, 1'b0);
		n = 0;
		while (sec_req_accept !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		chk(n > 20 && n < 32, 1'b1);
		lim(n, 100);
		// Secondary timeout of two units gates own requests while the bus is lent.
		acc(1'b1, 3'h4, 32'h00000100);
		own_req <= 1'b1;
		sec_grant <= 1'b1;
		cyc(5);
		chk(own_req_gated, 1'b0);
		cyc(24);
		chk(own_req_gated, 1'b0);
		cyc(8);
		chk(own_req_gated, 1'b1);
		sec_grant <= 1'b0;
		cyc(3);
		chk(own_req_gated, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
